// ===== hdl/edge_sync.sv
`timescale 1ns/1ps
module edge_sync (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Line in, registered level and edges out
   input wire logic line_in,
   output logic level_ff,
   output logic rise_ff,
   output logic fall_ff
);
   logic prev_ff;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         level_ff <= 1'b1;
         prev_ff <= 1'b1;
         rise_ff <= 1'b0;
         fall_ff <= 1'b0;
      end else begin
         level_ff <= line_in;
         prev_ff <= level_ff;
         rise_ff <= level_ff & ~prev_ff;
         fall_ff <= ~level_ff & prev_ff;
      end
   end
endmodule : edge_sync

// ===== hdl/rx_wake_ctrl.sv
`timescale 1ns/1ps
// Contract
// RULE1: Overflow flag sets once measure counter passes 16-bit divisor maximum before fifth rise.
// RULE2: Measure counter keeps counting after overflow until the fifth rising edge.
// RULE3: Fifth rising edge sets receive flag and clears auto-baud enable.
// RULE4: Reading receive data clears receive flag from measurement or wake-up.
// RULE5: Software may clear the overflow flag directly.
// RULE6: Overflow clear ignored while auto-baud enable is still set.
// RULE7: In sleep, serial clocks stop; no baud timing and no reception.
// RULE8: Break wake-up works only in asynchronous mode.
// RULE9: Wake enable disables normal reception; block idles watching the line.
// RULE10: Falling edge on receive line is the wake-up event.
// RULE11: Wake raises receive flag; synchronous when running, asynchronous in sleep.
// RULE12: Rising edge ending break clears wake enable; receiver returns to idle.
// RULE13: Non-zero character: start-to-first-rise low time taken as wake event.
// RULE14: Remote sends all-zero wake character of at least ten bit times.
// RULE15: Remote break and following gap long enough for oscillator start-up.
// RULE16: Software reads and discards receive data after wake-up.
// RULE17: Software checks receive idle before setting wake enable.
// RULE18: Receive idle high when no character, low from start bit to completion.
module rx_wake_ctrl #(
   parameter int DIVISOR_WIDTH = rx_wake_pkg::DIVISOR_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Receive line and mode
   input wire logic receive_line,
   input wire logic sleep_mode,
   input wire logic async_mode,
   // Software control strobes and bit timing
   input wire logic auto_baud_set,
   input wire logic auto_baud_clr,
   input wire logic wake_set,
   input wire logic wake_clr,
   input wire logic overflow_clr,
   input wire logic data_read,
   input wire logic [15:0] bit_cycles,
   // Status
   output logic auto_baud_enable,
   output logic wake_on_break_enable,
   output logic baud_measure_overflow_flag,
   output logic receive_interrupt_flag,
   output logic receive_idle_status,
   output logic [15:0] measured_divisor,
   output logic [7:0] receive_data_register
);
   import rx_wake_pkg::*;

   logic line_ff;
   logic rise_ff;
   logic fall_ff;
   logic abd_ff;
   logic wue_ff;
   logic ovf_ff;
   logic receive_interrupt_flag_ff;
   logic idle_ff;
   logic wake_async_ff;
   logic wake_ack_ff;
   logic [MEAS_W-1:0] meas_ff;
   logic [2:0] edges_ff;
   logic [15:0] div_ff;
   logic [7:0] data_ff;
   logic [15:0] tick_ff;
   logic [3:0] bit_ff;
   logic [7:0] shift_ff;
   rx_state_t state_ff;
   logic run;
   logic fifth;
   logic wake_ev;
   logic half;
   logic full;
   logic [MEAS_W-1:0] nxt_meas;

   edge_sync u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .line_in(receive_line),
      .level_ff(line_ff),
      .rise_ff(rise_ff),
      .fall_ff(fall_ff)
   );

   assign run = ~sleep_mode; // [RULE7]
   assign fifth = run && abd_ff && rise_ff && (edges_ff == MEAS_EDGES - 3'h1);
   assign wake_ev = run && wue_ff && async_mode && fall_ff; // [RULE8] [RULE10] [RULE13]
   // Wraps rather than saturates, so counting goes on past overflow
   assign nxt_meas = meas_ff + {{(MEAS_W-1){1'b0}}, 1'b1}; // [RULE2]
   assign half = (tick_ff == {1'b0, bit_cycles[15:1]});
   assign full = (tick_ff == bit_cycles - 16'h0001);

   // Measurement: counter starts on first rise, runs to the fifth
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meas_ff <= '0;
         edges_ff <= 3'h0;
         div_ff <= 16'h0000;
      end else if (run && abd_ff) begin
         if (rise_ff) begin
            edges_ff <= edges_ff + 3'h1;
         end
         if (edges_ff != 3'h0) begin
            meas_ff <= nxt_meas; // [RULE2]
         end
         if (fifth) begin
            div_ff <= nxt_meas[DIVISOR_W-1:0];
         end
      end else if (!abd_ff) begin
         meas_ff <= '0;
         edges_ff <= 3'h0;
      end
   end

   // Auto-baud enable
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         abd_ff <= 1'b0;
      end else if (fifth || auto_baud_clr) begin
         abd_ff <= 1'b0; // [RULE3]
      end else if (auto_baud_set && run) begin
         abd_ff <= 1'b1;
      end
   end

   // Overflow flag; set wins over clear, clear blocked while enabled
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ovf_ff <= 1'b0;
      end else if (run && abd_ff && meas_ff[MEAS_W-1] && !fifth) begin
         ovf_ff <= 1'b1; // [RULE1]
      end else if (overflow_clr && !abd_ff) begin
         ovf_ff <= 1'b0; // [RULE5] [RULE6]
      end
   end

   // Wake enable: set by software, cleared by the rise ending the break
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wue_ff <= 1'b0;
      end else if (wue_ff && run && rise_ff) begin
         wue_ff <= 1'b0; // [RULE12]
      end else if (wake_clr) begin
         wue_ff <= 1'b0;
      end else if (wake_set && async_mode) begin
         wue_ff <= 1'b1; // [RULE8] [RULE17]
      end
   end

   // Sleep-time wake: line watcher keeps running while the logic is frozen
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wake_async_ff <= 1'b0;
      end else if (wue_ff && async_mode && sleep_mode && fall_ff) begin
         wake_async_ff <= ~wake_ack_ff; // [RULE11]
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wake_ack_ff <= 1'b0;
      end else if (run) begin
         wake_ack_ff <= wake_async_ff;
      end
   end

   // Receive flag: set wins over read clear
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         receive_interrupt_flag_ff <= 1'b0;
      end else if (fifth || wake_ev || (run && (wake_async_ff ^ wake_ack_ff))
                   || (state_ff == RX_STOP && full)) begin
         receive_interrupt_flag_ff <= 1'b1; // [RULE3] [RULE11]
      end else if (data_read) begin
         receive_interrupt_flag_ff <= 1'b0; // [RULE4] [RULE16]
      end
   end

   // Character receiver, held idle during wake watch or measurement
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= RX_IDLE;
         tick_ff <= 16'h0000;
         bit_ff <= 4'h0;
         shift_ff <= 8'h00;
         data_ff <= 8'h00;
      end else if (!run || wue_ff || abd_ff) begin
         state_ff <= RX_IDLE; // [RULE7] [RULE9]
         tick_ff <= 16'h0000;
      end else begin
         tick_ff <= (state_ff == RX_IDLE || full) ? 16'h0000 : tick_ff + 16'h0001;
         unique case (state_ff)
            RX_IDLE: begin
               if (fall_ff) begin
                  state_ff <= RX_START;
               end
            end
            RX_START: begin
               if (half) begin
                  state_ff <= line_ff ? RX_IDLE : RX_DATA;
                  tick_ff <= 16'h0000;
                  bit_ff <= 4'h0;
               end
            end
            RX_DATA: begin
               if (full) begin
                  shift_ff <= {line_ff, shift_ff[7:1]};
                  bit_ff <= bit_ff + 4'h1;
                  if (bit_ff == CHAR_BITS - 4'h2) begin
                     state_ff <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (full) begin
                  state_ff <= RX_IDLE;
                  data_ff <= shift_ff;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         idle_ff <= 1'b1;
      end else begin
         idle_ff <= (state_ff == RX_IDLE); // [RULE18]
      end
   end

   // Registered outputs
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         auto_baud_enable <= 1'b0;
         wake_on_break_enable <= 1'b0;
         baud_measure_overflow_flag <= 1'b0;
         receive_interrupt_flag <= 1'b0;
         receive_idle_status <= 1'b1;
         measured_divisor <= 16'h0000;
         receive_data_register <= 8'h00;
      end else begin
         auto_baud_enable <= abd_ff;
         wake_on_break_enable <= wue_ff;
         baud_measure_overflow_flag <= ovf_ff;
         receive_interrupt_flag <= receive_interrupt_flag_ff || (wake_async_ff ^ wake_ack_ff);
         receive_idle_status <= idle_ff;
         measured_divisor <= div_ff;
         receive_data_register <= data_ff;
      end
   end
endmodule : rx_wake_ctrl

// ===== hdl/rx_wake_pkg.sv
package rx_wake_pkg;
   // Measurement counter width: one more than the 16-bit divisor pair
   localparam int DIVISOR_W = 16;
   localparam int MEAS_W = DIVISOR_W + 1;
   localparam logic [DIVISOR_W-1:0] DIVISOR_MAX = 16'hffff;
   localparam logic [2:0] MEAS_EDGES = 3'h5;
   // Clocks per receive bit at reset (oversampled receiver)
   localparam logic [15:0] BIT_CYCLES_RST = 16'h0010;
   localparam logic [3:0] CHAR_BITS = 4'h9;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage : rx_wake_pkg

// ===== tb/rx_wake_ctrl_asserts.sv
`timescale 1ns/1ps
module rx_wake_ctrl_asserts #(
   parameter int DIVISOR_WIDTH = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Inputs
   input wire logic receive_line,
   input wire logic sleep_mode,
   input wire logic async_mode,
   input wire logic wake_set,
   input wire logic overflow_clr,
   input wire logic data_read,
   // Status
   input wire logic auto_baud_enable,
   input wire logic wake_on_break_enable,
   input wire logic baud_measure_overflow_flag,
   input wire logic receive_interrupt_flag,
   input wire logic receive_idle_status,
   input wire logic [15:0] measured_divisor
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   AST_OVF_HOLD: assert property (
      auto_baud_enable && overflow_clr && baud_measure_overflow_flag
      |=> baud_measure_overflow_flag [*3]) else $error("overflow flag cleared early");
   AST_OVF_CLR: assert property (
      !auto_baud_enable && overflow_clr |-> ##[1:3] !baud_measure_overflow_flag)
      else $error("overflow flag not cleared");
   AST_WAKE_FLAG: assert property (
      !sleep_mode && wake_on_break_enable && $fell(receive_line)
      |-> ##[1:6] receive_interrupt_flag) else $error("no flag on wake");
   AST_WAKE_END: assert property (
      !sleep_mode && wake_on_break_enable && $rose(receive_line)
      |-> ##[1:6] !wake_on_break_enable) else $error("wake enable stuck");
   AST_READ_CLR: assert property (
      !sleep_mode && receive_interrupt_flag && data_read |-> ##[1:3] !receive_interrupt_flag)
      else $error("read did not clear flag");
   AST_WAKE_ASYNC: assert property (
      wake_set && !async_mode && !wake_on_break_enable |=> !wake_on_break_enable [*4])
      else $error("wake enabled outside async mode");
   AST_FREEZE: assert property (
      sleep_mode && $past(sleep_mode) && $past(sleep_mode, 2)
      |-> $stable(measured_divisor) && $stable(receive_idle_status))
      else $error("activity in sleep");
   AST_IDLE_WAKE: assert property (
      wake_on_break_enable |-> receive_idle_status) else $error("reception while wake set");
endmodule : rx_wake_ctrl_asserts

bind rx_wake_ctrl rx_wake_ctrl_asserts #(.DIVISOR_WIDTH(DIVISOR_WIDTH)) chk_u (.*);

// ===== tb/serial_tx_model.sv
`timescale 1ns/1ps
module serial_tx_model (
   // Clock
   input wire logic mclk,
   // Line, idle high
   output logic receive_line
);
   initial receive_line = 1'h1;
   task automatic hold(input logic lvl, input int bits, input int bt);
      receive_line = lvl;
      repeat (bits * bt) @(negedge mclk);
   endtask : hold
   // 8N1, LSB first
   task automatic send_char(input logic [7:0] d, input int bt);
      hold(1'h0, 1, bt);
      for (int i = 0; i < 8; i++) hold(d[i], 1, bt);
      hold(1'h1, 1, bt);
   endtask : send_char
   task automatic send_break(input int bt);
      hold(1'h0, 13, bt);
      hold(1'h1, 4, bt);
   endtask : send_break
endmodule : serial_tx_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import rx_wake_pkg::*;
   localparam int BT = 16;
   logic mclk = 1'h0, reset_n = 1'h0, sleep_mode = 1'h0, async_mode = 1'h1;
   logic auto_baud_set = 1'h0, auto_baud_clr = 1'h0, wake_set = 1'h0, wake_clr = 1'h0;
   logic overflow_clr = 1'h0, data_read = 1'h0;
   logic [15:0] bit_cycles = BIT_CYCLES_RST;
   logic receive_line, auto_baud_enable, wake_on_break_enable, baud_measure_overflow_flag;
   logic receive_interrupt_flag, receive_idle_status;
   logic [15:0] measured_divisor;
   logic [7:0] receive_data_register;
   int n_fail = 0;
   int tests_run = 0;
   always #2.5 mclk = ~mclk;
   serial_tx_model tx_u (.mclk(mclk), .receive_line(receive_line));
   rx_wake_ctrl dut_u (.*);
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic pulse(ref logic s);
      s = 1'h1;
      @(negedge mclk);
      s = 1'h0;
      repeat (8) @(negedge mclk);
   endtask : pulse
   task print_verdict;
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (8) @(negedge mclk);
      reset_n = 1'h1;
      repeat (2) @(negedge mclk);
      check("idle", receive_idle_status, 1'h1);
      fork
         tx_u.send_char(8'ha5, BT);
         begin
            repeat (5 * BT) @(negedge mclk);
            check("idle mid", receive_idle_status, 1'h0);
         end
      join
      check("rx done", receive_interrupt_flag, 1'h1);
      pulse(data_read);
      check("idle end", receive_idle_status, 1'h1);
      check("rx data", receive_data_register, 16'h00a5);
      pulse(auto_baud_set);
      tx_u.send_char(8'h55, BT);
      check("abd en", auto_baud_enable, 1'h0);
      check("rx flag", receive_interrupt_flag, 1'h1);
      check("ovf", baud_measure_overflow_flag, 1'h0);
      check("divisor", measured_divisor, 16'(8 * BT));
      pulse(data_read);
      check("rx clr", receive_interrupt_flag, 1'h0);
      pulse(auto_baud_set);
      pulse(auto_baud_clr);
      check("abd abort", auto_baud_enable, 1'h0);
      pulse(auto_baud_set);
      fork
         tx_u.send_char(8'h55, 8250);
         begin
            for (int i = 0; i < 80000 && baud_measure_overflow_flag !== 1'h1; i++) @(negedge mclk);
            if (baud_measure_overflow_flag !== 1'h1) begin
               n_fail++;
               print_verdict;
            end
            pulse(overflow_clr);
            check("ovf held", baud_measure_overflow_flag, 1'h1);
            check("abd run", auto_baud_enable, 1'h1);
         end
      join
      check("abd off", auto_baud_enable, 1'h0);
      check("ovf set", baud_measure_overflow_flag, 1'h1);
      pulse(overflow_clr);
      check("ovf clr", baud_measure_overflow_flag, 1'h0);
      pulse(data_read);
      pulse(wake_set);
      pulse(wake_clr);
      check("wake clr", wake_on_break_enable, 1'h0);
      async_mode = 1'h0;
      pulse(wake_set);
      check("wake sync", wake_on_break_enable, 1'h0);
      async_mode = 1'h1;
      check("idle pre", receive_idle_status, 1'h1);
      pulse(wake_set);
      fork
         tx_u.send_break(BT);
         begin
            repeat (6 * BT) @(negedge mclk);
            check("wake flag", receive_interrupt_flag, 1'h1);
            check("idle wake", receive_idle_status, 1'h1);
         end
      join
      check("wake end", wake_on_break_enable, 1'h0);
      pulse(data_read);
      check("rx clr", receive_interrupt_flag, 1'h0);
      pulse(wake_set);
      sleep_mode = 1'h1;
      fork
         tx_u.send_break(BT);
         begin
            repeat (5 * BT) @(negedge mclk);
            sleep_mode = 1'h0;
            repeat (8) @(negedge mclk);
            check("sleep wake", receive_interrupt_flag, 1'h1);
         end
      join
      check("wake end", wake_on_break_enable, 1'h0);
      pulse(data_read);
      pulse(wake_set);
      tx_u.send_char(8'h01, BT);
      check("frag wake", receive_interrupt_flag, 1'h1);
      check("frag end", wake_on_break_enable, 1'h0);
      print_verdict;
   end
endmodule : tb_top
